/* File: rtl/qbp_defines.vh */
// constants for the quasi-bidirectional port latch block
// assumes inclusion by bare name from the port module
`ifndef QBP_DEFINES_VH
`define QBP_DEFINES_VH

// latch reset value per port bit
`define QBP_LATCH_RST 1'b1

// port selector codes on the cpu side
`define QBP_PORT0 3'h0
`define QBP_PORT1 3'h1
`define QBP_PORT2 3'h2
`define QBP_PORT3 3'h3
`define QBP_PORT4 3'h4

// cpu operation codes
`define QBP_OP_NONE 3'h0
`define QBP_OP_WRITE 3'h1
`define QBP_OP_RD_LATCH 3'h2
`define QBP_OP_RD_PIN 3'h3
`define QBP_OP_RMW_BYTE 3'h4
`define QBP_OP_RMW_BIT 3'h5

// strong pull-up pulse length
`define QBP_BOOST_CYC 2'h2

// port 3 bits whose alternate input ignores the latch
`define QBP_P3_TXD_BIT 1
`define QBP_P3_WR_BIT 6

// port 4 bits
`define QBP_P4_CANTX_BIT 0
`define QBP_P4_CANRX_BIT 1

`endif

/* File: rtl/qbp_ports.v */
// five parallel port latches with quasi-bidirectional pin control
// assumes cpu strobes and pins synchronous to clk_sys (one osc period)
`timescale 1ns/1ps
`include "qbp_defines.vh"

module qbp_ports #(
	parameter W = 8, // port width
	parameter W4 = 2 // port 4 width
) (
	// clock and reset
	input wire clk_sys,
	input wire rst_n,
	// cpu side
	input wire [2:0] cpu_port,    // port selector
	input wire [2:0] cpu_op,      // operation code
	input wire [W-1:0] cpu_wdata, // write data or rmw operand result
	input wire [2:0] cpu_bit,     // bit index for bit ops
	input wire cpu_bit_val,       // new value for bit ops
	output reg [W-1:0] cpu_rdata, // read data
	output reg [W-1:0] rmw_src,   // latch value fed to rmw alu
	// external bus
	input wire bus_cycle,         // external memory cycle active
	input wire [W-1:0] bus_addr_lo, // multiplexed low address/data
	input wire [W-1:0] bus_addr_hi, // high address
	// alternate functions
	input wire [W-1:0] alt_out1,
	input wire [W-1:0] alt_out3,
	input wire can_tx_out,
	input wire [W-1:0] analog_sel1, // port 1 analog select
	output wire [W-1:0] alt_in3,    // gated port 3 alternate inputs
	output wire can_rx_in,          // gated can receive
	// pins
	input wire [W-1:0] p0_in,
	input wire [W-1:0] p1_in,
	input wire [W-1:0] p2_in,
	input wire [W-1:0] p3_in,
	input wire [W4-1:0] p4_in,
	output reg [W-1:0] p0_drv_low,  // nfet on
	output reg [W-1:0] p0_drv_high, // strong pfet on
	output reg [W-1:0] p1_drv_low,
	output reg [W-1:0] p2_drv_low,
	output reg [W-1:0] p3_drv_low,
	output reg [W4-1:0] p4_drv_low,
	output reg [W-1:0] p1_boost, // short strong pull-up
	output reg [W-1:0] p2_boost,
	output reg [W-1:0] p3_boost,
	output reg [W4-1:0] p4_boost,
	output reg [W-1:0] p1_keeper, // weak keeper pull-up
	output reg [W-1:0] p2_keeper,
	output reg [W-1:0] p3_keeper,
	output reg [W4-1:0] p4_keeper,
	output reg [W-1:0] p1_vweak,  // very weak pull-up
	output reg [W-1:0] p2_vweak,
	output reg [W-1:0] p3_vweak,
	output reg [W4-1:0] p4_vweak
);

// -----------------------------------------------------------------
// latches
// -----------------------------------------------------------------
reg [W-1:0] lat0_q, lat1_q, lat2_q, lat3_q; // port output latches
reg [W4-1:0] lat4_q; // two-bit port 4
reg [W-1:0] cur_lat; // selected latch
reg [W-1:0] cur_pin; // selected pins
reg [W-1:0] new_val; // value to write back
reg wr_en; // latch update this cycle

// select latch and pins of addressed port
always @* begin
	cur_lat = {W{1'b0}};
	cur_pin = {W{1'b0}};
	case (cpu_port)
		`QBP_PORT0: begin
			cur_lat = lat0_q;
			cur_pin = p0_in;
		end
		`QBP_PORT1: begin
			cur_lat = lat1_q;
			cur_pin = p1_in;
		end
		`QBP_PORT2: begin
			cur_lat = lat2_q;
			cur_pin = p2_in;
		end
		`QBP_PORT3: begin
			cur_lat = lat3_q;
			cur_pin = p3_in;
		end
		`QBP_PORT4: begin
			cur_lat = {{(W-W4){1'b0}}, lat4_q};
			cur_pin = {{(W-W4){1'b0}}, p4_in};
		end
		default: begin
			cur_lat = {W{1'b0}};
		end
	endcase
end

// compute written value
always @* begin
	new_val = cpu_wdata;
	wr_en = 1'b0;
	rmw_src = cur_lat; // rmw source is latch
	case (cpu_op)
		`QBP_OP_WRITE, `QBP_OP_RMW_BYTE: begin
			wr_en = 1'b1;
		end
		`QBP_OP_RMW_BIT: begin
			new_val = cur_lat;
			new_val[cpu_bit] = cpu_bit_val;
			wr_en = 1'b1;
		end
		default: begin
			wr_en = 1'b0;
		end
	endcase
end

// latch update, registered at operation end
// reset to ones
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		lat0_q <= {W{`QBP_LATCH_RST}};
		lat1_q <= {W{`QBP_LATCH_RST}};
		lat2_q <= {W{`QBP_LATCH_RST}};
		lat3_q <= {W{`QBP_LATCH_RST}};
		lat4_q <= {W4{`QBP_LATCH_RST}};
	end else if (wr_en) begin
		case (cpu_port)
			`QBP_PORT0: lat0_q <= new_val;
			`QBP_PORT1: lat1_q <= new_val;
			`QBP_PORT2: lat2_q <= new_val;
			`QBP_PORT3: lat3_q <= new_val;
			`QBP_PORT4: lat4_q <= new_val[W4-1:0];
			default: lat0_q <= lat0_q;
		endcase
	end
end

// read data register
// read latch or pin
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		cpu_rdata <= {W{1'b0}};
	end else if (cpu_op == `QBP_OP_RD_LATCH) begin
		cpu_rdata <= cur_lat;
	end else if (cpu_op == `QBP_OP_RD_PIN) begin
		cpu_rdata <= cur_pin;
	end
end

// -----------------------------------------------------------------
// boost pulse after rising latch bits
// -----------------------------------------------------------------
reg [W-1:0] prev1_q, prev2_q, prev3_q; // latch one cycle ago
reg [W4-1:0] prev4_q;
reg [W-1:0] rise1_q, rise2_q, rise3_q; // second boost cycle
reg [W4-1:0] rise4_q;
wire [W-1:0] up1 = lat1_q & ~prev1_q;
wire [W-1:0] up2 = lat2_q & ~prev2_q;
wire [W-1:0] up3 = lat3_q & ~prev3_q;
wire [W4-1:0] up4 = lat4_q & ~prev4_q;

// track previous latch and stretch rise to two cycles
// two-period boost window
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		prev1_q <= {W{`QBP_LATCH_RST}};
		prev2_q <= {W{`QBP_LATCH_RST}};
		prev3_q <= {W{`QBP_LATCH_RST}};
		prev4_q <= {W4{`QBP_LATCH_RST}};
		rise1_q <= {W{1'b0}};
		rise2_q <= {W{1'b0}};
		rise3_q <= {W{1'b0}};
		rise4_q <= {W4{1'b0}};
	end else begin
		prev1_q <= lat1_q;
		prev2_q <= lat2_q;
		prev3_q <= lat3_q;
		prev4_q <= lat4_q;
		rise1_q <= up1;
		rise2_q <= up2;
		rise3_q <= up3;
		rise4_q <= up4;
	end
end

// -----------------------------------------------------------------
// pin drivers, one cycle behind the latch
// -----------------------------------------------------------------
wire [W-1:0] lvl0 = bus_cycle ? bus_addr_lo : lat0_q;
wire [W-1:0] lvl2 = bus_cycle ? bus_addr_hi : lat2_q;
wire [W-1:0] lvl1 = lat1_q & alt_out1;
// sized one-hot masks, so no 32-bit shift result is cut silently
wire [W-1:0] p3_free = ({{(W-1){1'b0}}, 1'b1} << `QBP_P3_TXD_BIT) |
	({{(W-1){1'b0}}, 1'b1} << `QBP_P3_WR_BIT);
wire [W-1:0] lvl3 = lat3_q & alt_out3;
wire [W4-1:0] lvl4 = lat4_q & {{(W4-1){1'b1}}, can_tx_out};

assign alt_in3 = p3_in & (lat3_q | p3_free);
assign can_rx_in = p4_in[`QBP_P4_CANRX_BIT] & lat4_q[`QBP_P4_CANRX_BIT];

// register pin control
// pins follow next cycle
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		p0_drv_low <= {W{1'b0}};
		p0_drv_high <= {W{1'b0}};
		p1_drv_low <= {W{1'b0}};
		p2_drv_low <= {W{1'b0}};
		p3_drv_low <= {W{1'b0}};
		p4_drv_low <= {W4{1'b0}};
		p1_boost <= {W{1'b0}};
		p2_boost <= {W{1'b0}};
		p3_boost <= {W{1'b0}};
		p4_boost <= {W4{1'b0}};
		p1_keeper <= {W{1'b0}};
		p2_keeper <= {W{1'b0}};
		p3_keeper <= {W{1'b0}};
		p4_keeper <= {W4{1'b0}};
		p1_vweak <= {W{1'b0}};
		p2_vweak <= {W{1'b0}};
		p3_vweak <= {W{1'b0}};
		p4_vweak <= {W4{1'b0}};
	end else begin
		p0_drv_low <= ~lvl0;
		p1_drv_low <= ~lvl1;
		p2_drv_low <= ~lvl2;
		p3_drv_low <= ~lvl3;
		p4_drv_low <= ~lvl4;
		// port 0 high side only in bus
		p0_drv_high <= bus_cycle ? bus_addr_lo : {W{1'b0}};
		// port 1 pull-ups off on analog
		p1_boost <= (up1 | rise1_q) & ~analog_sel1;
		// port 2 strong high in bus
		p2_boost <= bus_cycle ? bus_addr_hi : (up2 | rise2_q);
		p3_boost <= up3 | rise3_q;
		p4_boost <= up4 | rise4_q;
		p1_keeper <= p1_in & lvl1 & ~analog_sel1;
		p2_keeper <= p2_in & lvl2;
		p3_keeper <= p3_in & lvl3;
		p4_keeper <= p4_in & lvl4;
		p1_vweak <= lvl1 & ~analog_sel1;
		p2_vweak <= lvl2;
		p3_vweak <= lvl3;
		p4_vweak <= lvl4;
	end
end

endmodule // qbp_ports

/* File: verification/qbp_pin_model.sv */
// outside circuit on one quasi-bidirectional port
// assumes the device pull-ups hold released pins high
`timescale 1ns/1ps
module qbp_pin_model #(
	parameter N = 8 // pins on the port
) (
	// device and outside drives
	input wire logic [N-1:0] drv_low,
	input wire logic [N-1:0] ext_low,
	// resolved level
	output logic [N-1:0] pin
);
	// pulled-up input
	// low wins, otherwise the pull-up gives one
	assign pin = ~drv_low & ~ext_low;
endmodule // qbp_pin_model

/* File: verification/qbp_ports_asserts.sv */
// checker on the port latch block pins
// assumes one clock domain, bound into qbp_ports
`timescale 1ns/1ps
module qbp_ports_chk #(
	parameter W = 8,
	parameter W4 = 2
) (
	// clock and reset
	input wire clk_sys,
	input wire rst_n,
	// cpu side
	input wire [2:0] cpu_port,
	input wire [2:0] cpu_op,
	input wire [W-1:0] cpu_wdata,
	input wire [2:0] cpu_bit,
	input wire cpu_bit_val,
	input wire [W-1:0] cpu_rdata,
	input wire [W-1:0] rmw_src,
	// bus and pins
	input wire bus_cycle,
	input wire [W-1:0] bus_addr_hi,
	input wire [W-1:0] p3_in,
	input wire [W-1:0] alt_in3,
	input wire [W-1:0] p0_drv_high,
	input wire [W-1:0] p1_drv_low,
	input wire [W-1:0] p2_drv_low,
	input wire [W-1:0] p1_boost
);
	// ----
	// properties
	// ----
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_wr; (cpu_op == 3'h1 && cpu_port == 3'h1) |-> ##2 p1_drv_low == ~$past(cpu_wdata, 2); endproperty
	a_wr: assert property (p_wr) else $error("write not on pins");
	property p_rdl; (cpu_op == 3'h2 && cpu_port < 3'h4) |=> cpu_rdata == $past(rmw_src); endproperty
	a_rdl: assert property (p_rdl) else $error("latch read wrong");
	property p_rdp; (cpu_op == 3'h3 && cpu_port == 3'h3) |=> cpu_rdata == $past(p3_in); endproperty
	a_rdp: assert property (p_rdp) else $error("pin read wrong");
	property p_bit; (cpu_op == 3'h5 && cpu_port < 3'h4) ##1 (cpu_port == $past(cpu_port)) |->
		rmw_src == (($past(rmw_src) & ~(8'h01 << $past(cpu_bit))) | ({7'h00, $past(cpu_bit_val)} << $past(cpu_bit)));
	endproperty
	a_bit: assert property (p_bit) else $error("bit op changed other bits");
	property p_bst; $rose(p1_boost[0]) |-> p1_boost[0] [*2] ##1 !p1_boost[0]; endproperty
	a_bst: assert property (p_bst) else $error("boost length wrong");
	property p_p0; !bus_cycle |=> p0_drv_high == 8'h00; endproperty
	a_p0: assert property (p_p0) else $error("port 0 high outside bus");
	property p_p2; bus_cycle |=> p2_drv_low == ~$past(bus_addr_hi); endproperty
	a_p2: assert property (p_p2) else $error("port 2 not on address");
	property p_alt; cpu_port == 3'h3 |-> alt_in3 == (p3_in & (rmw_src | 8'h42)); endproperty
	a_alt: assert property (p_alt) else $error("alternate input gating");
	c_wr: cover property (cpu_op == 3'h1 ##2 p1_boost != 8'h00);
	c_bus: cover property (bus_cycle ##1 p2_drv_low != 8'h00);
	c_bit: cover property (cpu_op == 3'h5);
endmodule // qbp_ports_chk
bind qbp_ports qbp_ports_chk #(.W(W), .W4(W4)) u_chk (.*);

/* File: verification/quasi_bidir_port_latches_bench.sv */
// self-checking bench for the port latch block
// assumes pin models on ports 1 to 3, ports 0 and 4 held high
`timescale 1ns/1ps
module quasi_bidir_port_latches_bench;
	// ----
	// signals
	// ----
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] cpu_port = 3'h0, cpu_op = 3'h0, cpu_bit = 3'h0;
	logic cpu_bit_val = 1'b0, bus_cycle = 1'b0, can_rx_in;
	logic [7:0] cpu_wdata = 8'h00, bus_addr_lo = 8'h00, bus_addr_hi = 8'h00;
	logic [7:0] alt_out3 = 8'hFF, ext3 = 8'h00, cpu_rdata, rmw_src, alt_in3;
	logic [7:0] p1_in, p2_in, p3_in, p0_drv_low, p0_drv_high, p1_drv_low, p2_drv_low;
	logic [7:0] p3_drv_low, p1_boost, p2_boost, p3_boost, p1_keeper, p2_keeper, p3_keeper;
	logic [7:0] p1_vweak, p2_vweak, p3_vweak;
	logic [1:0] p4_drv_low, p4_boost, p4_keeper, p4_vweak;
	wire [7:0] alt_out1 = 8'hFF, analog_sel1 = 8'h00, p0_in = 8'hFF;
	wire [1:0] p4_in = 2'h3;
	wire can_tx_out = 1'b1;
	int err_total = 0, compares = 0, cyc = 0;
	always #2.5 clk_sys = ~clk_sys;
	qbp_ports dut (.*);
	qbp_pin_model u_p1 (.drv_low(p1_drv_low), .ext_low(8'h00), .pin(p1_in));
	qbp_pin_model u_p2 (.drv_low(p2_drv_low), .ext_low(8'h00), .pin(p2_in));
	qbp_pin_model u_p3 (.drv_low(p3_drv_low), .ext_low(ext3), .pin(p3_in));
	// compare and report
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// one cpu request, taken at the next rising edge
	task automatic op(input [2:0] p, input [2:0] o, input [7:0] d);
		@(negedge clk_sys);
		cpu_port = p;
		cpu_op = o;
		cpu_wdata = d;
		@(negedge clk_sys);
		cpu_op = 3'h0;
	endtask
	task automatic conclude();
		if (err_total == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// reset values of every latch
	task automatic t_reset();
		for (int p = 0; p < 4; p++) begin
			op(p[2:0], 3'h2, 8'h00);
			chk("latch", 8'hFF, cpu_rdata);
		end
		op(3'h4, 3'h2, 8'h00);
		chk("latch4", 8'h03, {6'h00, cpu_rdata[1:0]});
		chk("can rx", 8'h01, {7'h00, can_rx_in});
		chk("p1 pin", 8'hFF, p1_in);
		chk("p1 keeper", 8'hFF, p1_keeper);
		chk("p1 vweak", 8'hFF, p1_vweak);
	endtask
	// write, pin read, then release with boost
	task automatic t_write();
		op(3'h1, 3'h1, 8'h5A);
		@(negedge clk_sys);
		chk("p1 drv", 8'hA5, p1_drv_low);
		op(3'h1, 3'h3, 8'h00);
		chk("p1 pin", 8'h5A, cpu_rdata);
		op(3'h1, 3'h1, 8'hFF);
		repeat (2) begin
			@(negedge clk_sys);
			chk("p1 boost", 8'hA5, p1_boost);
		end
		@(negedge clk_sys);
		chk("p1 boost", 8'h00, p1_boost);
	endtask
	// pins held low outside, latch ops still see ones
	task automatic t_rmw();
		ext3 = 8'hFF;
		op(3'h3, 3'h3, 8'h00);
		chk("p3 pin", 8'h00, cpu_rdata);
		chk("p3 rmw", 8'hFF, rmw_src);
		cpu_bit = 3'h2;
		op(3'h3, 3'h5, 8'h00);
		op(3'h3, 3'h2, 8'h00);
		chk("p3 latch", 8'hFB, cpu_rdata);
		ext3 = 8'h00;
		alt_out3 = 8'h0F;
		@(negedge clk_sys);
		chk("p3 alt", 8'hF4, p3_drv_low);
		alt_out3 = 8'hFF;
	endtask
	// external bus on ports 0 and 2
	task automatic t_bus();
		bus_addr_lo = 8'h3C;
		bus_addr_hi = 8'hC3;
		bus_cycle = 1'b1;
		@(negedge clk_sys);
		chk("p0 high", 8'h3C, p0_drv_high);
		chk("p2 drv", 8'h3C, p2_drv_low);
		chk("p2 boost", 8'hC3, p2_boost);
		bus_cycle = 1'b0;
		@(negedge clk_sys);
		chk("p0 high", 8'h00, p0_drv_high);
		chk("p0 drv", 8'h00, p0_drv_low);
	endtask
	// hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			conclude();
		end
	end
	// main sequence, reset held well past the minimum
	initial begin
		repeat (12) @(negedge clk_sys);
		rst_n = 1'b1;
		t_reset();
		t_write();
		t_rmw();
		t_bus();
		conclude();
	end
endmodule // quasi_bidir_port_latches_bench
